/* amo_pkg.sv */
// package: register map, field layout, reset values for alarm/offset bank
package amo_pkg;
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 16;
  localparam logic [6:0]  ADDR_TEMP      = 7'h06;
  localparam logic [6:0]  ADDR_MASK      = 7'h07;
  localparam logic [6:0]  ADDR_OFFS_A    = 7'h08;
  localparam logic [6:0]  ADDR_OFFS_B    = 7'h09;
  localparam logic [15:0] RST_MASK       = 16'hFFFF;
  localparam logic [15:0] RST_OFFS_A     = 16'h0000;
  localparam logic [15:0] RST_OFFS_B     = 16'h8000;
  localparam logic [15:0] USED_ALARMS    = 16'hBFBC;
  localparam logic [15:0] MID_SCALE      = 16'h8000;
  localparam int          OFFS_W         = 13;
  localparam int          PRESET_LSB     = 13;
  localparam int          PRESET_W       = 3;
  localparam int          TEMP_LSB       = 8;
  localparam int          ALM_OUT_FORCED = 8;
  localparam int          ALM_ZERO_PTR   = 15;
  localparam logic [12:0] OFFS_ZERO      = 13'h0000;
  localparam logic [15:0] ZERO16         = 16'h0000;
endpackage : amo_pkg

/* amo_alarm_gate.sv */
// alarm status capture and mask gating toward the external alarm pin
module amo_alarm_gate
  import amo_pkg::*;
(
  input  wire logic        mclk,        // clock
  input  wire logic        rst_n,       // async reset, active low
  input  wire logic [15:0] alarm_src,   // raw alarm sources
  input  wire logic [15:0] mask,        // 1 = masked
  input  wire logic        clr_stb,     // clear recorded status
  output logic      [15:0] status,      // sticky recorded alarms
  output logic             alarm_out    // unmasked alarm summary
);
  logic [15:0] status_d;
  logic        alarm_d;
  // set wins over clear; masked alarms are still recorded
  assign status_d = ((clr_stb ? ZERO16 : status) | alarm_src) & USED_ALARMS;
  assign alarm_d  = |(status_d & ~mask);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status    <= ZERO16;
      alarm_out <= 1'b0;
    end else begin
      status    <= status_d;
      alarm_out <= alarm_d;
    end
  end
endmodule // amo_alarm_gate

/* amo_regs.sv */
// register bank: die temperature, alarm mask, A/B offset trim, ptr preset
// all registers sit on mclk; the temperature byte has no reset and
// simply follows the sensor one cycle late
module amo_regs
  import amo_pkg::*;
#(
  parameter int OFFS_BITS   = amo_pkg::OFFS_W,   // trim field width
  parameter int PRESET_BITS = amo_pkg::PRESET_W  // read-pointer preset width
)
(
  input  wire logic                     mclk,            // clock
  input  wire logic                     rst_n,           // async reset
  input  wire logic                     reg_wr,          // write strobe
  input  wire logic                     reg_rd,          // read strobe
  input  wire logic [amo_pkg::ADDR_W-1:0] reg_addr,      // register index
  input  wire logic [amo_pkg::DATA_W-1:0] reg_wdata,     // write data
  output logic      [amo_pkg::DATA_W-1:0] reg_rdata,     // read data
  input  wire logic [7:0]               temp_sensor,     // sensor code
  input  wire logic                     auto_sync_ena,   // from sync-enable
  input  wire logic                     fifo_sync,       // fifo sync pulse
  input  wire logic [7:0]               wr_ptr,          // fifo write ptr
  input  wire logic [15:0]              alarm_src,       // raw alarms
  input  wire logic                     alarm_clr,       // clear status
  input  wire logic [15:0]              chan_a_data,     // path A sample
  input  wire logic [15:0]              chan_b_data,     // path B sample
  output logic      [OFFS_BITS-1:0]     chan_a_offset_corr, // applied A
  output logic      [OFFS_BITS-1:0]     chan_b_offset_corr, // applied B
  output logic                          auto_sync_pulse, // auto-sync event
  output logic      [PRESET_BITS-1:0]   rd_ptr_load,     // preset to load
  output logic                          rd_ptr_load_stb, // load strobe
  output logic                          wr_ptr_stuck,    // ptr stuck flag
  output logic      [15:0]              alarm_status,    // recorded alarms
  output logic                          alarm_out,       // external alarm
  output logic      [15:0]              output_channel_a, // path A out
  output logic      [15:0]              output_channel_b  // path B out
);
  import amo_pkg::*;

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  // register 9 packs the preset above the B trim; wider fields would
  // overlap inside the one word
  if (OFFS_BITS < 1 || OFFS_BITS > PRESET_LSB || PRESET_BITS < 1 ||
      PRESET_LSB + PRESET_BITS > DATA_W) begin : g_width_check
    $error("offset or preset width does not fit the register word");
  end

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [DATA_W-1:0]      mask_q;
  logic [DATA_W-1:0]      offs_a_q;
  logic [DATA_W-1:0]      offs_b_q;
  logic [DATA_W-1:0]      temp_q;
  logic [DATA_W-1:0]      rdata_d;
  logic [OFFS_BITS-1:0]   corr_a_q;
  logic [OFFS_BITS-1:0]   corr_b_q;
  logic                   sync_q;
  logic                   stuck_q;
  logic                   load_q;
  logic [PRESET_BITS-1:0] load_val_q;
  logic [DATA_W-1:0]      out_a_q;
  logic [DATA_W-1:0]      out_b_q;
  logic [DATA_W-1:0]      src_all;

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  wire wr_mask = reg_wr && (reg_addr == ADDR_MASK);
  wire wr_a    = reg_wr && (reg_addr == ADDR_OFFS_A);
  wire wr_b    = reg_wr && (reg_addr == ADDR_OFFS_B);
  wire do_sync = wr_a && auto_sync_ena;
  wire zero_wp = (wr_ptr == 8'h00);
  // sync wins: the pointer is reloaded on that edge, so it is not zero
  wire stuck_d = fifo_sync ? 1'b0 : (zero_wp || stuck_q);

  // trim field of a register word; used for the store and both applies
  function automatic logic [OFFS_BITS-1:0] offs_of(
    input logic [DATA_W-1:0] v
  );
    offs_of = v[OFFS_BITS-1:0];
  endfunction

  // stored A word: reserved upper bits read back as zero
  function automatic logic [DATA_W-1:0] offs_field(
    input logic [DATA_W-1:0] v
  );
    logic [DATA_W-1:0] f;
    f = ZERO16;
    f[OFFS_BITS-1:0] = offs_of(v);
    offs_field = f;
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q   <= RST_MASK;
      offs_a_q <= RST_OFFS_A;
      offs_b_q <= RST_OFFS_B;
    end else begin
      if (wr_mask) mask_q <= reg_wdata;
      if (wr_a) offs_a_q <= offs_field(reg_wdata);
      // register 9 keeps all 16 bits: the preset rides in the same word
      if (wr_b) offs_b_q <= reg_wdata;
    end
  end

  // sensor sample has no reset; it simply tracks the sensor
  always_ff @(posedge mclk) begin
    temp_q <= {temp_sensor, 8'h00};
  end

  // ------------------------------------------------------------------
  // offset apply: only auto-sync moves the applied pair, together
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      corr_a_q <= OFFS_BITS'(OFFS_ZERO);
      corr_b_q <= OFFS_BITS'(OFFS_ZERO);
      sync_q   <= 1'b0;
    end else begin
      sync_q <= do_sync;
      if (do_sync) begin
        // A comes from the write itself so both land on one edge
        corr_a_q <= offs_of(reg_wdata);
        corr_b_q <= offs_of(offs_b_q);
      end
    end
  end

  // ------------------------------------------------------------------
  // fifo pointer preset and zero-pointer lock
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      load_q     <= 1'b0;
      load_val_q <= RST_OFFS_B[PRESET_LSB +: PRESET_BITS];
      stuck_q    <= 1'b0;
    end else begin
      load_q     <= fifo_sync;
      load_val_q <= offs_b_q[PRESET_LSB +: PRESET_BITS];
      stuck_q    <= stuck_d;
    end
  end

  assign src_all = alarm_src | ({15'h0000, zero_wp} << ALM_ZERO_PTR);

  amo_alarm_gate u_gate (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .alarm_src (src_all),
    .mask      (mask_q),
    .clr_stb   (alarm_clr),
    .status    (alarm_status),
    .alarm_out (alarm_out)
  );

  // ------------------------------------------------------------------
  // output path: mid-scale while the output-forced alarm stands
  // ------------------------------------------------------------------
  // forced follows the recorded status bit, so the outputs stay at
  // mid-scale until the alarm is cleared, not only while it is raw
  wire              forced  = alarm_status[ALM_OUT_FORCED];
  wire [DATA_W-1:0] out_a_d = forced ? MID_SCALE : chan_a_data;
  wire [DATA_W-1:0] out_b_d = forced ? MID_SCALE : chan_b_data;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_a_q <= MID_SCALE;
      out_b_q <= MID_SCALE;
    end else begin
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
    end
  end

  // ------------------------------------------------------------------
  // read mux; unmapped indexes read zero
  // ------------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      ADDR_TEMP:   rdata_d = temp_q;
      ADDR_MASK:   rdata_d = mask_q;
      ADDR_OFFS_A: rdata_d = offs_a_q;
      ADDR_OFFS_B: rdata_d = offs_b_q;
      default:     rdata_d = ZERO16;
    endcase
  end

  // read data holds between reads so a slow host can sample it late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= ZERO16;
    else if (reg_rd) reg_rdata <= rdata_d;
  end

  assign chan_a_offset_corr = corr_a_q;
  assign chan_b_offset_corr = corr_b_q;
  assign auto_sync_pulse    = sync_q;
  assign rd_ptr_load        = load_val_q;
  assign rd_ptr_load_stb    = load_q;
  assign wr_ptr_stuck       = stuck_q;
  assign output_channel_a   = out_a_q;
  assign output_channel_b   = out_b_q;
endmodule // amo_regs

/* amo_host.sv */
// host model: drives the strobe-style register port of the bank
module amo_host
  import amo_pkg::*;
(
  input  wire logic        mclk,      // clock
  output logic             reg_wr,    // write strobe
  output logic             reg_rd,    // read strobe
  output logic [6:0]       reg_addr,  // register index
  output logic [15:0]      reg_wdata, // write data
  input  wire logic [15:0] reg_rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  // one slow serial period of 1 us at the 5 ns clock before a sensor read
  localparam int TEMP_GAP = 200;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic req(input logic w, input logic [6:0] a,
                     input logic [15:0] d);
    if (!w && a == ADDR_TEMP) repeat (TEMP_GAP) @(negedge mclk);
    @(negedge mclk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge mclk);
    // released lines flip so a stale index is never mistaken for a request
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // amo_host

/* amo_checker.sv */
// checker: port-level properties of the alarm/offset register bank
module amo_checker
  import amo_pkg::*;
(
  input wire logic        mclk,               // clock
  input wire logic        rst_n,              // reset
  input wire logic        reg_wr,             // write
  input wire logic [6:0]  reg_addr,           // index
  input wire logic [15:0] reg_wdata,          // data
  input wire logic        auto_sync_ena,      // sync on
  input wire logic        fifo_sync,          // sync
  input wire logic [7:0]  wr_ptr,             // ptr
  input wire logic [12:0] chan_a_offset_corr, // corr a
  input wire logic [12:0] chan_b_offset_corr, // corr b
  input wire logic        auto_sync_pulse,    // event
  input wire logic        rd_ptr_load_stb,    // load
  input wire logic        wr_ptr_stuck,       // stuck
  input wire logic [15:0] alarm_status,       // status
  input wire logic        alarm_out,          // alarm
  input wire logic [15:0] output_channel_a    // out a
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence a_wr_s;
    reg_wr && reg_addr == ADDR_OFFS_A && auto_sync_ena;
  endsequence
  sync_load_a: assert property (a_wr_s |=> auto_sync_pulse &&
    chan_a_offset_corr == $past(reg_wdata[12:0])) else $error("no auto-sync");
  pair_hold_a: assert property (!auto_sync_pulse |->
    $stable(chan_a_offset_corr) && $stable(chan_b_offset_corr))
    else $error("offset moved without auto-sync");
  load_strobe_a: assert property (fifo_sync |=> rd_ptr_load_stb
    && !wr_ptr_stuck) else $error("sync did not load pointer");
  ptr_stuck_a: assert property (wr_ptr == 8'h00 && !fifo_sync |=>
    wr_ptr_stuck && alarm_status[ALM_ZERO_PTR]) else $error("no stuck");
  stuck_hold_a: assert property (wr_ptr_stuck && !fifo_sync |=>
    wr_ptr_stuck) else $error("stuck flag dropped early");
  unused_bits_a: assert property ((alarm_status & ~USED_ALARMS) == ZERO16)
    else $error("unused alarm bit set");
  mask_gate_a: assert property (alarm_out |-> alarm_status != ZERO16)
    else $error("alarm without recorded cause");
  mid_scale_a: assert property (alarm_status[ALM_OUT_FORCED] &&
    $past(alarm_status[ALM_OUT_FORCED]) |-> output_channel_a == MID_SCALE)
    else $error("output not mid-scale");
endmodule // amo_checker
bind amo_regs amo_checker amo_checker_inst (.mclk, .rst_n, .reg_wr,
  .reg_addr, .reg_wdata, .auto_sync_ena, .fifo_sync, .wr_ptr,
  .chan_a_offset_corr, .chan_b_offset_corr, .auto_sync_pulse,
  .rd_ptr_load_stb, .wr_ptr_stuck, .alarm_status, .alarm_out,
  .output_channel_a);

/* testbench.sv */
// testbench: register access, offset sync and alarm checks for the bank
module testbench
  import amo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst_n = 1'b0, auto_sync_ena = 1'b0;
  logic        fifo_sync = 1'b0, alarm_clr = 1'b0;
  logic [7:0]  temp_sensor = 8'hE7, wr_ptr = 8'h5A;
  logic [15:0] alarm_src = 16'h0000;
  logic [15:0] chan_a_data = 16'h1357, chan_b_data = 16'h2468;
  logic        reg_wr, reg_rd, auto_sync_pulse, rd_ptr_load_stb;
  logic        wr_ptr_stuck, alarm_out;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, alarm_status, output_channel_a;
  logic [15:0] output_channel_b;
  logic [12:0] chan_a_offset_corr, chan_b_offset_corr;
  logic [2:0]  rd_ptr_load;
  int          bad_count = 0, total_checks = 0;
  amo_host amo_host_inst (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);
  amo_regs amo_regs_inst (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .temp_sensor, .auto_sync_ena, .fifo_sync,
    .wr_ptr, .alarm_src, .alarm_clr, .chan_a_data, .chan_b_data,
    .chan_a_offset_corr, .chan_b_offset_corr, .auto_sync_pulse,
    .rd_ptr_load, .rd_ptr_load_stb, .wr_ptr_stuck, .alarm_status,
    .alarm_out, .output_channel_a, .output_channel_b);
  always #2.5 mclk = ~mclk;
  task automatic chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    amo_host_inst.req(1'b0, a, 16'h0000);
    chk("rdata", reg_rdata, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    amo_host_inst.req(1'b1, a, d);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    chk("preset", {13'h0, rd_ptr_load}, 16'h0004);
    rchk(ADDR_TEMP, 16'hE700);
    rchk(ADDR_MASK, 16'hFFFF);
    rchk(ADDR_OFFS_A, 16'h0000);
    rchk(ADDR_OFFS_B, 16'h8000);
    rchk(7'h10, 16'h0000);
    wr(ADDR_TEMP, 16'h1234);
    rchk(ADDR_TEMP, 16'hE700);
    $display("access test done");
    wr(ADDR_OFFS_A, 16'hF555);
    chk("corr_a", {3'h0, chan_a_offset_corr}, 16'h0000);
    chk("sync", {15'h0, auto_sync_pulse}, 16'h0000);
    rchk(ADDR_OFFS_A, 16'h1555);
    wr(ADDR_OFFS_B, 16'h6ABC);
    chk("corr_b", {3'h0, chan_b_offset_corr}, 16'h0000);
    auto_sync_ena = 1'b1;
    wr(ADDR_OFFS_A, 16'h0FED);
    chk("corr_a", {3'h0, chan_a_offset_corr}, 16'h0FED);
    chk("corr_b", {3'h0, chan_b_offset_corr}, 16'h0ABC);
    chk("sync", {15'h0, auto_sync_pulse}, 16'h0001);
    fifo_sync = 1'b1;
    @(negedge mclk) fifo_sync = 1'b0;
    chk("load", {13'h0, rd_ptr_load}, 16'h0003);
    chk("load_stb", {15'h0, rd_ptr_load_stb}, 16'h0001);
    $display("offset test done");
    wr(ADDR_MASK, 16'hFFFF);
    alarm_src = 16'h0100;
    @(negedge mclk) alarm_src = 16'h0000;
    repeat (2) @(negedge mclk);
    chk("status", alarm_status, 16'h0100);
    chk("alarm", {15'h0, alarm_out}, 16'h0000);
    chk("out_a", output_channel_a, MID_SCALE);
    chk("out_b", output_channel_b, MID_SCALE);
    wr(ADDR_MASK, 16'hFEFF);
    @(negedge mclk);
    chk("alarm", {15'h0, alarm_out}, 16'h0001);
    alarm_clr = 1'b1;
    @(negedge mclk) alarm_clr = 1'b0;
    repeat (2) @(negedge mclk);
    chk("out_a", output_channel_a, chan_a_data);
    chk("out_b", output_channel_b, chan_b_data);
    chk("status", alarm_status, 16'h0000);
    wr_ptr = 8'h00;
    @(negedge mclk) wr_ptr = 8'h5A;
    repeat (2) @(negedge mclk);
    chk("stuck", {15'h0, wr_ptr_stuck}, 16'h0001);
    chk("status", alarm_status, 16'h8000);
    chk("alarm", {15'h0, alarm_out}, 16'h0000);
    fifo_sync = 1'b1;
    @(negedge mclk) fifo_sync = 1'b0;
    chk("stuck", {15'h0, wr_ptr_stuck}, 16'h0000);
    $display("alarm test done");
    report_and_stop;
  end
  // sensor reads are paced at 1 us, so the tests take about 2.2 us;
  // 20 us means a hang
  initial begin
    #20000;
    bad_count++;
    report_and_stop;
  end
endmodule // testbench
